// *** pkg/bfsmc_defs.svh ***
/*
 * Constants of the four-sensor bidirectional muting controller: register offsets, control bit positions,
 * reset values, allowed ranges and timing counts.
 * Assumes a 10 MHz system clock and a register port with 32-bit data.
 */
// Operation
// - time mode: pair within window starts muting
// - pair window expiry stops muting at once
// - exit sensor release ends muting
// - extension time 0..1000 ms, default 0
// - minimum pair separation 0..1000 ms, default 100
// - pair window 1..16 s, default 4
// - muting timeout 10..57600 s, default 600
// - infinite timeout removes duration limit
// - deactivation filter 0..1000 ms, default 0
// - activation filter 0..1000 ms, default 0
// - dynamic teach 500..4000 ms limits zone
// - beam tolerance 0..6 above taught height
// - start-from-top counts zone from top
// - lamp check verifies external indicator lamp
// - level override ends when signals drop
// - edge override continues after signals drop
// - override timeout 1..256 min, default 2
// - automatic restart keeps outputs, resumes monitoring
// - manual restart interlocks until restart signal
// - sequence mode needs strict sensor order
// - simultaneous or wrong order stops muting
// - mute-enable input gates new requests
`ifndef BFSMC_DEFS_SVH
`define BFSMC_DEFS_SVH

// ****************************************
// timing
// ****************************************
`define BFSMC_CLK_PERIOD_NS 100
`define BFSMC_MS_NS         1000000
`define BFSMC_MS_CYCLES     (`BFSMC_MS_NS / `BFSMC_CLK_PERIOD_NS)
`define BFSMC_MS_PER_S      26'h00003E8
`define BFSMC_MS_PER_MIN    26'h000EA60

// ****************************************
// register offsets
// ****************************************
`define BFSMC_REG_CTRL    8'h00
`define BFSMC_REG_T12MIN  8'h04
`define BFSMC_REG_T12MAX  8'h08
`define BFSMC_REG_TDELAY  8'h0C
`define BFSMC_REG_TIMEOUT 8'h10
`define BFSMC_REG_DEACT   8'h14
`define BFSMC_REG_ACT     8'h18
`define BFSMC_REG_TEACH   8'h1C
`define BFSMC_REG_OVRTMO  8'h20
`define BFSMC_REG_STATUS  8'h24
`define BFSMC_REG_TAUGHT  8'h28

// ****************************************
// control bits
// ****************************************
`define BFSMC_CTRL_SEQ     0
`define BFSMC_CTRL_INF     1
`define BFSMC_CTRL_DYN     2
`define BFSMC_CTRL_TOP     3
`define BFSMC_CTRL_LAMP    4
`define BFSMC_CTRL_EDGE    5
`define BFSMC_CTRL_MANUAL  6
`define BFSMC_CTRL_ENUSED  7
`define BFSMC_CTRL_TOL_LSB 8
`define BFSMC_CTRL_RESET   16'h0000

// ****************************************
// ranges and reset values
// ****************************************
`define BFSMC_T12MIN_RST  16'h0064
`define BFSMC_T12MIN_MAX  16'h03E8
`define BFSMC_T12MAX_RST  16'h0004
`define BFSMC_T12MAX_MIN  16'h0001
`define BFSMC_T12MAX_MAX  16'h0010
`define BFSMC_TDELAY_MAX  16'h03E8
`define BFSMC_TMO_RST     16'h0258
`define BFSMC_TMO_MIN     16'h000A
`define BFSMC_TMO_MAX     16'hE100
`define BFSMC_FILT_MAX    16'h03E8
`define BFSMC_TEACH_RST   16'h07D0
`define BFSMC_TEACH_MIN   16'h01F4
`define BFSMC_TEACH_MAX   16'h0FA0
`define BFSMC_OVR_RST     16'h0002
`define BFSMC_OVR_MIN     16'h0001
`define BFSMC_OVR_MAX     16'h0100
`define BFSMC_TOL_MAX     16'h0006
`define BFSMC_ZERO16      16'h0000

// ****************************************
// status bits
// ****************************************
`define BFSMC_ST_WIN    0
`define BFSMC_ST_SEP    1
`define BFSMC_ST_SEQ    2
`define BFSMC_ST_TMO    3
`define BFSMC_ST_LAMP   4
`define BFSMC_ST_MUTE   8
`define BFSMC_ST_DIR    9
`define BFSMC_ST_OVR    10
`define BFSMC_ST_ILOCK  11
`define BFSMC_ST_TAUGHT 12

`endif

// *** pkg/bfsmc_pkg.sv ***
/*
 * Types of the four-sensor bidirectional muting controller.
 * Assumes bfsmc_defs.svh for the numeric constants.
 */
`default_nettype none

package bfsmc_pkg;
	typedef enum logic [2:0] {MS_IDLE, MS_PAIR, MS_MUTE, MS_DELAY, MS_WAIT_CLR} bfsmc_mute_e;
	typedef enum logic [1:0] {OV_IDLE, OV_RUN, OV_LOCK} bfsmc_ovr_e;
endpackage : bfsmc_pkg

`default_nettype wire

// *** verif/bfsmc_field.sv ***
/* far-side model: four muting sensors, override buttons, restart pin, lamp sense.
   assumes the bench calls its tasks; pins change just after a rising edge. */
`default_nettype none
module bfsmc_field (
	// clock and lamp drive
	input  wire logic       i_clock,
	input  wire logic       i_lamp_on,
	// pins
	output logic      [3:0] o_sensor,
	output logic      [1:0] o_override,
	output logic            o_restart,
	output logic            o_lamp_sense,
	output logic            o_mute_enable
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		o_sensor = 4'h0;
		o_override = 2'h0;
		o_restart = 1'b0;
		o_mute_enable = 1'b1;
	end
	assign o_lamp_sense = i_lamp_on; // intact lamp
	task pin(input int n, input logic v);
		@(posedge i_clock) o_sensor[n] <= v;
	endtask : pin
	// buttons stay down for the whole override
	task press(input logic v);
		@(posedge i_clock) o_override <= {v, v};
	endtask : press
	task restart;
		@(posedge i_clock) o_restart <= 1'b1;
		repeat (4) @(posedge i_clock);
		o_restart <= 1'b0;
	endtask : restart
endmodule : bfsmc_field
`default_nettype wire

// *** verif/tb.sv ***
/* self-checking bench of the muting controller.
   assumes bfsmc_core with a 10-cycle millisecond and the field model. */
`include "bfsmc_defs.svh"
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        i_clock = 1'b0;
	logic        i_rst = 1'b1;
	logic        i_wr = 1'b0;
	logic        i_rd = 1'b0;
	logic [7:0]  i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0;
	logic [31:0] o_rdata;
	logic [3:0]  sensor;
	logic [1:0]  ovr;
	logic        rst_pin, lamp_sense, men, mute, ovr_on, lock, lamp;
	logic [2:0]  obs;
	logic [6:0]  zone;
	logic        top;
	int          miscompares = 0;
	int          checks = 0;
	int          cycles = 0;
	assign obs = {lock, ovr_on, mute};
	always #50 i_clock = ~i_clock;
	bfsmc_core #(.MS_CYCLES(10)) uut (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sensor(sensor), .i_mute_enable(men),
		.i_override(ovr), .i_manual_restart(rst_pin), .i_lamp_sense(lamp_sense), .i_beams_blocked(7'h00),
		.o_muting_active(mute), .o_zone_limit(zone), .o_zone_from_top(top), .o_override_active(ovr_on),
		.o_interlock(lock), .o_lamp_on(lamp));
	bfsmc_field field (.i_clock(i_clock), .i_lamp_on(lamp), .o_sensor(sensor), .o_override(ovr),
		.o_restart(rst_pin), .o_lamp_sense(lamp_sense), .o_mute_enable(men));
	// ****************************************
	// bus and compare tasks
	// ****************************************
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clock) begin
			i_wr <= 1'b1;
			i_addr <= a;
			i_wdata <= d;
		end
		@(posedge i_clock) i_wr <= 1'b0;
	endtask : wr
	task rdc(input logic [7:0] a, input logic [31:0] exp);
		@(posedge i_clock) begin
			i_rd <= 1'b1;
			i_addr <= a;
		end
		@(posedge i_clock) i_rd <= 1'b0;
		#1 chk(o_rdata, exp);
	endtask : rdc
	// bounded wait for one output, then compare it
	task wt(input int i, input logic e, input int n);
		int k;
		k = 0;
		#1;
		while (k < n && obs[i] !== e) begin
			@(posedge i_clock);
			#1 k++;
		end
		chk({31'h0, obs[i]}, {31'h0, e});
	endtask : wt
	task conclude;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : conclude
	// ****************************************
	// scenarios
	// ****************************************
	task t_reset;
		rdc(`BFSMC_REG_T12MIN, 32'(`BFSMC_T12MIN_RST));
		rdc(`BFSMC_REG_T12MAX, 32'(`BFSMC_T12MAX_RST));
		rdc(`BFSMC_REG_TDELAY, 32'h0);
		rdc(`BFSMC_REG_TIMEOUT, 32'(`BFSMC_TMO_RST));
		rdc(`BFSMC_REG_DEACT, 32'h0);
		rdc(`BFSMC_REG_ACT, 32'h0);
		rdc(`BFSMC_REG_TEACH, 32'(`BFSMC_TEACH_RST));
		rdc(`BFSMC_REG_OVRTMO, 32'(`BFSMC_OVR_RST));
		rdc(`BFSMC_REG_CTRL, 32'h0);
		rdc(8'h2C, 32'h0);
		chk({25'h0, zone}, 32'h40);
		wr(`BFSMC_REG_CTRL, 32'h8);
		repeat (2) @(posedge i_clock);
		#1 chk({31'h0, top}, 32'h1);
		wr(`BFSMC_REG_CTRL, 32'h0);
		$display("test reset done");
	endtask : t_reset
	task t_time;
		wr(`BFSMC_REG_T12MIN, 32'h1);
		wr(`BFSMC_REG_TDELAY, 32'h3);
		field.pin(0, 1'b1);
		repeat (30) @(posedge i_clock);
		field.pin(1, 1'b1);
		wt(0, 1'b1, 8);
		field.pin(2, 1'b1);
		field.pin(0, 1'b0);
		field.pin(1, 1'b0);
		field.pin(2, 1'b0);
		repeat (20) @(posedge i_clock);
		wt(0, 1'b1, 0);
		wt(0, 1'b0, 20);
		field.pin(3, 1'b1);
		repeat (30) @(posedge i_clock);
		field.pin(2, 1'b1);
		wt(0, 1'b1, 8);
		rdc(`BFSMC_REG_STATUS, 32'h300);
		field.pin(1, 1'b1);
		field.pin(3, 1'b0);
		field.pin(2, 1'b0);
		field.pin(1, 1'b0);
		wt(0, 1'b0, 50);
		field.pin(0, 1'b1);
		field.pin(1, 1'b1);
		repeat (10) @(posedge i_clock);
		rdc(`BFSMC_REG_STATUS, 32'h2);
		field.pin(0, 1'b0);
		field.pin(1, 1'b0);
		wr(`BFSMC_REG_STATUS, 32'h1F);
		$display("test time mode done");
	endtask : t_time
	task t_window;
		wr(`BFSMC_REG_T12MAX, 32'h1);
		field.pin(0, 1'b1);
		repeat (9980) @(posedge i_clock);
		rdc(`BFSMC_REG_STATUS, 32'h0);
		repeat (30) @(posedge i_clock);
		rdc(`BFSMC_REG_STATUS, 32'h1);
		field.pin(0, 1'b0);
		wr(`BFSMC_REG_STATUS, 32'h1F);
		$display("test window done");
	endtask : t_window
	task t_seq;
		wr(`BFSMC_REG_CTRL, 32'h1);
		field.pin(1, 1'b1);
		repeat (10) @(posedge i_clock);
		rdc(`BFSMC_REG_STATUS, 32'h4);
		field.pin(1, 1'b0);
		wr(`BFSMC_REG_STATUS, 32'h1F);
		repeat (10) @(posedge i_clock);
		field.pin(0, 1'b1);
		repeat (30) @(posedge i_clock);
		field.pin(1, 1'b1);
		wt(0, 1'b1, 8);
		field.pin(2, 1'b1);
		field.pin(3, 1'b1);
		field.pin(0, 1'b0);
		field.pin(1, 1'b0);
		field.pin(2, 1'b0);
		wt(0, 1'b0, 50);
		field.pin(3, 1'b0);
		$display("test sequence done");
	endtask : t_seq
	task t_override;
		wr(`BFSMC_REG_CTRL, 32'h40);
		field.press(1'b1);
		wt(1, 1'b1, 8);
		field.press(1'b0);
		wt(2, 1'b1, 8);
		wt(1, 1'b0, 0);
		field.restart();
		wt(2, 1'b0, 8);
		$display("test override done");
	endtask : t_override
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			conclude();
		end
	end
	initial begin
		repeat (16) @(posedge i_clock);
		i_rst <= 1'b0;
		t_reset();
		t_time();
		t_window();
		t_seq();
		t_override();
		conclude();
	end
endmodule : tb
`default_nettype wire

// *** verilog/bfsmc_core.sv ***
/*
 * Four-sensor bidirectional muting controller with time or sequence monitoring, input filters,
 * dynamic zone teach, lamp check and override handling, configured over a plain register port.
 * Assumes pins arrive asynchronous, beam count comes from logic on i_clock.
 */
// Decided for this implementation: the strobed register port and the register addresses.
`include "bfsmc_defs.svh"
`default_nettype none

module bfsmc_core
	import bfsmc_pkg::*;
#(
	parameter int MS_CYCLES = `BFSMC_MS_CYCLES,
	parameter int BEAMS     = 64
) (
	// clock and reset
	input  wire logic                     i_clock,
	input  wire logic                     i_rst,
	// register port
	input  wire logic [7:0]               i_addr,
	input  wire logic [31:0]              i_wdata,
	input  wire logic                     i_wr,
	input  wire logic                     i_rd,
	output logic      [31:0]              o_rdata,
	// pins
	input  wire logic [3:0]               i_sensor,
	input  wire logic                     i_mute_enable,
	input  wire logic [1:0]               i_override,
	input  wire logic                     i_manual_restart,
	input  wire logic                     i_lamp_sense,
	// beam evaluation
	input  wire logic [$clog2(BEAMS+1)-1:0] i_beams_blocked,
	output logic                          o_muting_active,
	output logic      [$clog2(BEAMS+1)-1:0] o_zone_limit,
	output logic                          o_zone_from_top,
	// override and lamp
	output logic                          o_override_active,
	output logic                          o_interlock,
	output logic                          o_lamp_on
);
	localparam int TW = $clog2(MS_CYCLES + 1);
	localparam int BW = $clog2(BEAMS + 1);

	if (MS_CYCLES < 2 || BEAMS < 7) begin : g_chk
		$error("bfsmc_core: MS_CYCLES must be >= 2 and BEAMS >= 7");
	end

	function automatic logic [15:0] clampv(input logic [31:0] v, input logic [15:0] lo, input logic [15:0] hi);
		if (v < {16'h0000, lo}) begin
			clampv = lo;
		end else if (v > {16'h0000, hi}) begin
			clampv = hi;
		end else begin
			clampv = v[15:0];
		end
	endfunction : clampv

	// ****************************************
	// millisecond tick
	// ****************************************
	logic [TW-1:0] tick_cnt_q;
	wire           tick = (tick_cnt_q == TW'(MS_CYCLES - 1));

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
		end
	end

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [8:0] pin_m_q;
	logic [8:0] pin_s_q;

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			pin_m_q <= '0;
			pin_s_q <= '0;
		end else begin
			pin_m_q <= {i_lamp_sense, i_manual_restart, i_override, i_mute_enable, i_sensor};
			pin_s_q <= pin_m_q;
		end
	end

	wire [3:0] sens_raw  = pin_s_q[3:0];
	wire       en_s      = pin_s_q[4];
	wire       ov_both   = &pin_s_q[6:5];
	wire       restart_s = pin_s_q[7];
	wire       lamp_s    = pin_s_q[8];

	// ****************************************
	// configuration registers
	// ****************************************
	logic [15:0] ctrl_q, t12min_q, t12max_q, tdelay_q, tmo_q, deact_q, act_q, teach_q, ovrtmo_q;
	logic [4:0]  sticky_q;
	logic [31:0] rd_mux;

	wire       cfg_seq    = ctrl_q[`BFSMC_CTRL_SEQ];
	wire       cfg_inf    = ctrl_q[`BFSMC_CTRL_INF];
	wire       cfg_dyn    = ctrl_q[`BFSMC_CTRL_DYN];
	wire       cfg_lamp   = ctrl_q[`BFSMC_CTRL_LAMP];
	wire       cfg_edge   = ctrl_q[`BFSMC_CTRL_EDGE];
	wire       cfg_manual = ctrl_q[`BFSMC_CTRL_MANUAL];
	wire       cfg_enused = ctrl_q[`BFSMC_CTRL_ENUSED];
	wire [2:0] cfg_tol    = ctrl_q[`BFSMC_CTRL_TOL_LSB +: 3];
	wire [15:0] tol_wr    = clampv({29'h0, i_wdata[`BFSMC_CTRL_TOL_LSB +: 3]}, `BFSMC_ZERO16, `BFSMC_TOL_MAX);

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			ctrl_q   <= `BFSMC_CTRL_RESET;
			t12min_q <= `BFSMC_T12MIN_RST;
			t12max_q <= `BFSMC_T12MAX_RST;
			tdelay_q <= `BFSMC_ZERO16;
			tmo_q    <= `BFSMC_TMO_RST;
			deact_q  <= `BFSMC_ZERO16;
			act_q    <= `BFSMC_ZERO16;
			teach_q  <= `BFSMC_TEACH_RST;
			ovrtmo_q <= `BFSMC_OVR_RST;
		end else if (i_wr) begin
			if (i_addr == `BFSMC_REG_CTRL) begin
				ctrl_q <= {5'h00, tol_wr[2:0], i_wdata[7:0]};
			end else if (i_addr == `BFSMC_REG_T12MIN) begin
				t12min_q <= clampv(i_wdata, `BFSMC_ZERO16, `BFSMC_T12MIN_MAX);
			end else if (i_addr == `BFSMC_REG_T12MAX) begin
				t12max_q <= clampv(i_wdata, `BFSMC_T12MAX_MIN, `BFSMC_T12MAX_MAX);
			end else if (i_addr == `BFSMC_REG_TDELAY) begin
				tdelay_q <= clampv(i_wdata, `BFSMC_ZERO16, `BFSMC_TDELAY_MAX);
			end else if (i_addr == `BFSMC_REG_TIMEOUT) begin
				tmo_q <= clampv(i_wdata, `BFSMC_TMO_MIN, `BFSMC_TMO_MAX);
			end else if (i_addr == `BFSMC_REG_DEACT) begin
				deact_q <= clampv(i_wdata, `BFSMC_ZERO16, `BFSMC_FILT_MAX);
			end else if (i_addr == `BFSMC_REG_ACT) begin
				act_q <= clampv(i_wdata, `BFSMC_ZERO16, `BFSMC_FILT_MAX);
			end else if (i_addr == `BFSMC_REG_TEACH) begin
				teach_q <= clampv(i_wdata, `BFSMC_TEACH_MIN, `BFSMC_TEACH_MAX);
			end else if (i_addr == `BFSMC_REG_OVRTMO) begin
				ovrtmo_q <= clampv(i_wdata, `BFSMC_OVR_MIN, `BFSMC_OVR_MAX);
			end
		end
	end

	// ****************************************
	// input filters
	// ****************************************
	logic [3:0] sf_q;
	logic [9:0] fcnt_q [4];

	for (genvar g = 0; g < 4; g++) begin : g_filt
		wire [9:0] lim = sens_raw[g] ? act_q[9:0] : deact_q[9:0];
		always_ff @(posedge i_clock or posedge i_rst) begin
			if (i_rst) begin
				sf_q[g]   <= 1'b0;
				fcnt_q[g] <= '0;
			end else if (sens_raw[g] == sf_q[g]) begin
				fcnt_q[g] <= '0;
			end else if (fcnt_q[g] >= lim) begin
				sf_q[g]   <= sens_raw[g];
				fcnt_q[g] <= '0;
			end else if (tick) begin
				fcnt_q[g] <= fcnt_q[g] + 1'b1;
			end
		end
	end

	// ****************************************
	// muting sequencer
	// ****************************************
	bfsmc_mute_e st_q, st_d;
	logic        dir_q, dir_d;
	logic        exit_seen_q;
	logic [25:0] ph_ms_q;
	logic        lamp_on_q;
	// lamp sense lags the drive by the synchroniser; judge only a settled drive
	logic [2:0]  lamp_hist_q;

	// lead, pair partner, exit and last sensor for the current direction
	wire s_lead  = dir_q ? sf_q[3] : sf_q[0];
	wire s_pair  = dir_q ? sf_q[2] : sf_q[1];
	wire s_exit  = dir_q ? sf_q[1] : sf_q[2];
	wire s_last  = dir_q ? sf_q[0] : sf_q[3];
	wire fwd_any = sf_q[0] | sf_q[1];
	wire rev_any = sf_q[2] | sf_q[3];

	wire [25:0] win_ms = 26'(t12max_q[4:0] * `BFSMC_MS_PER_S);
	wire [25:0] tmo_ms = 26'(tmo_q * `BFSMC_MS_PER_S);
	wire        lamp_bad = cfg_lamp & (&lamp_hist_q) & lamp_on_q & ~lamp_s;
	wire        accept   = (~cfg_enused | en_s) & ~lamp_bad;
	wire        ev_win   = (st_q == MS_PAIR) & ~cfg_seq & ~s_pair & (ph_ms_q >= win_ms);
	wire        ev_sep   = (st_q == MS_PAIR) & ~cfg_seq & s_pair & (ph_ms_q < {10'h000, t12min_q});
	wire        ev_tmo   = (st_q == MS_MUTE) & ~cfg_inf & (ph_ms_q >= tmo_ms);
	wire        idle_req = (st_q == MS_IDLE) & accept;
	wire        ev_seq_i = idle_req & cfg_seq & ((sf_q[0] & sf_q[1]) | (sf_q[3] & sf_q[2]) |
	                       ((sf_q[1] | sf_q[2]) & ~sf_q[0] & ~sf_q[3]));
	wire        ev_seq_p = (st_q == MS_PAIR) & cfg_seq & (s_exit | s_last);
	wire        ev_seq_m = (st_q == MS_MUTE) & cfg_seq & s_last & ~exit_seen_q;
	wire        ev_seq   = ev_seq_i | ev_seq_p | ev_seq_m;

	always_comb begin
		st_d  = st_q;
		dir_d = dir_q;
		case (st_q)
			MS_IDLE: begin
				if (ev_seq_i) begin
					st_d = MS_WAIT_CLR;
				end else if (accept && fwd_any != rev_any) begin
					dir_d = rev_any;
					if (cfg_seq) begin
						st_d = MS_PAIR;
					end else if ((sf_q[0] & sf_q[1]) | (sf_q[2] & sf_q[3])) begin
						st_d = (t12min_q == `BFSMC_ZERO16) ? MS_MUTE : MS_WAIT_CLR;
					end else begin
						st_d = MS_PAIR;
					end
				end
			end
			MS_PAIR: begin
				if (ev_seq_p || ev_sep || ev_win) begin
					st_d = MS_WAIT_CLR;
				end else if (s_pair) begin
					st_d = MS_MUTE;
				end else if (!s_lead) begin
					st_d = MS_IDLE;
				end
			end
			MS_MUTE: begin
				if (ev_seq_m || ev_tmo) begin
					st_d = MS_WAIT_CLR;
				end else if (exit_seen_q && !s_exit) begin
					st_d = (tdelay_q == `BFSMC_ZERO16) ? MS_WAIT_CLR : MS_DELAY;
				end
			end
			MS_DELAY: begin
				if (ph_ms_q >= {10'h000, tdelay_q}) begin
					st_d = MS_WAIT_CLR;
				end
			end
			default: begin
				if (sf_q == 4'h0) begin
					st_d = MS_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			st_q        <= MS_IDLE;
			dir_q       <= 1'b0;
			exit_seen_q <= 1'b0;
			ph_ms_q     <= '0;
		end else begin
			st_q        <= st_d;
			dir_q       <= dir_d;
			exit_seen_q <= (st_d == MS_MUTE) & (exit_seen_q | ((st_q == MS_MUTE) & s_exit));
			if (st_d != st_q) begin
				ph_ms_q <= '0;
			end else if (tick && !(&ph_ms_q)) begin
				ph_ms_q <= ph_ms_q + 1'b1;
			end
		end
	end

	// ****************************************
	// override
	// ****************************************
	bfsmc_ovr_e  ov_q, ov_d;
	logic        ov_both_q;
	logic        restart_q;
	logic [25:0] ov_ms_q;

	wire [25:0] ov_lim   = 26'(ovrtmo_q[8:0] * `BFSMC_MS_PER_MIN);
	wire        ov_start = ov_both & ~ov_both_q;
	wire        ov_tmo   = ov_ms_q >= ov_lim;
	wire        rst_rise = restart_s & ~restart_q;
	wire        ov_end   = ov_tmo | (~cfg_edge & ~ov_both);

	always_comb begin
		ov_d = ov_q;
		case (ov_q)
			OV_IDLE: begin
				if (ov_start) begin
					ov_d = OV_RUN;
				end
			end
			OV_RUN: begin
				if (ov_end) begin
					ov_d = cfg_manual ? OV_LOCK : OV_IDLE;
				end
			end
			default: begin
				if (rst_rise) begin
					ov_d = OV_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			ov_q      <= OV_IDLE;
			ov_both_q <= 1'b0;
			restart_q <= 1'b0;
			ov_ms_q   <= '0;
		end else begin
			ov_q      <= ov_d;
			ov_both_q <= ov_both;
			restart_q <= restart_s;
			if (ov_q != OV_RUN) begin
				ov_ms_q <= '0;
			end else if (tick) begin
				ov_ms_q <= ov_ms_q + 1'b1;
			end
		end
	end

	// ****************************************
	// dynamic zone teach
	// ****************************************
	logic [11:0] teach_ms_q;
	logic [BW-1:0] taught_q;
	logic        taught_done_q;

	wire           mute_d   = (st_d == MS_MUTE) | (st_d == MS_DELAY) | (ov_d == OV_RUN);
	wire [BW:0]    zone_sum = {1'b0, taught_q} + (BW + 1)'(cfg_tol);
	wire [BW-1:0]  zone_d   = (!cfg_dyn || !taught_done_q) ? BW'(BEAMS) :
	                          (zone_sum > (BW + 1)'(BEAMS)) ? BW'(BEAMS) : zone_sum[BW-1:0];

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			teach_ms_q    <= '0;
			taught_q      <= '0;
			taught_done_q <= 1'b0;
		end else if (!o_muting_active) begin
			teach_ms_q    <= '0;
			taught_q      <= '0;
			taught_done_q <= 1'b0;
		end else if (!taught_done_q) begin
			taught_q <= (i_beams_blocked > taught_q) ? i_beams_blocked : taught_q;
			if (teach_ms_q >= teach_q[11:0]) begin
				taught_done_q <= 1'b1;
			end else if (tick) begin
				teach_ms_q <= teach_ms_q + 1'b1;
			end
		end
	end

	// ****************************************
	// outputs and status
	// ****************************************
	wire [4:0] st_set = {lamp_bad, ev_tmo, ev_seq, ev_sep, ev_win};
	wire [4:0] st_clr = (i_wr && i_addr == `BFSMC_REG_STATUS) ? i_wdata[4:0] : 5'h00;

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_muting_active   <= 1'b0;
			o_zone_limit      <= '0;
			o_zone_from_top   <= 1'b0;
			o_override_active <= 1'b0;
			o_interlock       <= 1'b0;
			lamp_on_q         <= 1'b0;
			lamp_hist_q       <= 3'h0;
			sticky_q          <= '0;
			o_rdata           <= '0;
		end else begin
			o_muting_active   <= mute_d;
			o_zone_limit      <= zone_d;
			o_zone_from_top   <= ctrl_q[`BFSMC_CTRL_TOP];
			o_override_active <= (ov_d == OV_RUN);
			o_interlock       <= (ov_d == OV_LOCK);
			lamp_on_q         <= mute_d;
			lamp_hist_q       <= {lamp_hist_q[1:0], lamp_on_q};
			sticky_q          <= (sticky_q & ~st_clr) | st_set;
			o_rdata           <= i_rd ? rd_mux : 32'h0000_0000;
		end
	end

	assign o_lamp_on = lamp_on_q;

	always_comb begin
		if (i_addr == `BFSMC_REG_CTRL) begin
			rd_mux = {16'h0000, ctrl_q};
		end else if (i_addr == `BFSMC_REG_T12MIN) begin
			rd_mux = {16'h0000, t12min_q};
		end else if (i_addr == `BFSMC_REG_T12MAX) begin
			rd_mux = {16'h0000, t12max_q};
		end else if (i_addr == `BFSMC_REG_TDELAY) begin
			rd_mux = {16'h0000, tdelay_q};
		end else if (i_addr == `BFSMC_REG_TIMEOUT) begin
			rd_mux = {16'h0000, tmo_q};
		end else if (i_addr == `BFSMC_REG_DEACT) begin
			rd_mux = {16'h0000, deact_q};
		end else if (i_addr == `BFSMC_REG_ACT) begin
			rd_mux = {16'h0000, act_q};
		end else if (i_addr == `BFSMC_REG_TEACH) begin
			rd_mux = {16'h0000, teach_q};
		end else if (i_addr == `BFSMC_REG_OVRTMO) begin
			rd_mux = {16'h0000, ovrtmo_q};
		end else if (i_addr == `BFSMC_REG_STATUS) begin
			rd_mux = {19'h00000, taught_done_q, o_interlock, o_override_active, dir_q, o_muting_active,
			          3'h0, sticky_q};
		end else if (i_addr == `BFSMC_REG_TAUGHT) begin
			rd_mux = 32'(taught_q);
		end else begin
			rd_mux = 32'h0000_0000;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	property p_window;
		ev_win |=> (st_q == MS_WAIT_CLR) && !o_muting_active;
	endproperty
	a_window: assert property (p_window) else $error("pair window expiry did not stop muting");

	property p_min_sep;
		ev_sep && ov_q != OV_RUN |=> st_q == MS_WAIT_CLR && !o_muting_active;
	endproperty
	a_min_sep: assert property (p_min_sep) else $error("pair too close did not abort");

	property p_seq_wrong;
		ev_seq_i |=> st_q == MS_WAIT_CLR ##1 st_q != MS_MUTE;
	endproperty
	a_seq_wrong: assert property (p_seq_wrong) else $error("wrong sequence accepted");

	property p_enable;
		st_q == MS_IDLE && cfg_enused && !en_s |=> st_q == MS_IDLE;
	endproperty
	a_enable: assert property (p_enable) else $error("request accepted without mute enable");

	property p_timeout;
		ev_tmo && !ev_seq_m |=> st_q == MS_WAIT_CLR && $past(ph_ms_q) >= tmo_ms;
	endproperty
	a_timeout: assert property (p_timeout) else $error("muting timeout not applied");

	property p_infinite;
		cfg_inf && st_q == MS_MUTE && !ev_seq_m && !(exit_seen_q && !s_exit) |=> st_q == MS_MUTE;
	endproperty
	a_infinite: assert property (p_infinite) else $error("infinite muting ended early");

	property p_delay;
		st_q == MS_DELAY && ov_q == OV_IDLE |-> o_muting_active;
	endproperty
	a_delay: assert property (p_delay) else $error("muting dropped during extension");

	property p_level_ovr;
		ov_q == OV_RUN && !cfg_edge && !ov_both |=> ov_q != OV_RUN ##1 !o_override_active;
	endproperty
	a_level_ovr: assert property (p_level_ovr) else $error("level override kept running");

	property p_edge_ovr;
		ov_q == OV_RUN && cfg_edge && !ov_tmo |=> ov_q == OV_RUN;
	endproperty
	a_edge_ovr: assert property (p_edge_ovr) else $error("edge override stopped early");

	property p_manual;
		ov_q == OV_LOCK && !rst_rise |=> ov_q == OV_LOCK && o_interlock;
	endproperty
	a_manual: assert property (p_manual) else $error("interlock left without restart");

	property p_tick;
		tick |=> !tick [*2];
	endproperty
	a_tick: assert property (p_tick) else $error("millisecond tick too frequent");

endmodule : bfsmc_core

`default_nettype wire
